/* File: rtl/ufc_top.sv */
// uart flow control, special character detect and modem line block
//
// Function
// - With detection on, every received character is compared with pause char two, a match sets status bit 4 and is stored unless it is also a flow character.
// - Bit 0 of the match character lines up with the first received (least significant) data bit.
// - With receive mode 10, flow control and special detection run side by side independently.
// - With receive mode 01 and detection on, pause char two is not stored and raises both the pause and the special event.
// - The request-to-send pin is used for automatic receive flow control only when enhanced bit 6 is one.
// - With auto request-to-send, the trigger level raises an event and the upper level drives request-to-send high.
// - With auto request-to-send, the pin goes low again once the fill drops below the lower level.
// - Auto request-to-send has no effect unless software has asserted request-to-send in modem control.
// - With hardware flow control off, request-to-send simply follows its modem control bit.
// - With enhanced bit 7 set, transmission stops while clear-to-send is high and resumes when it is low.
// - Special detect, auto request-to-send and auto clear-to-send all reset disabled.
// - Four read/write 8-bit resume and pause character registers reset to zero.
// - The divisor resets to high 0x00, low 0x01 only at power-up, not on the reset pin.
// - On reset the modem status change bits clear and the upper bits show the inverted inputs.
// - The low two enhanced bits select receive compare: 10 first pair, 01 second pair, 00 off.
`timescale 1ns/1ps
`include "ufc_params.svh"

module ufc_top #(
    parameter int CNT_W = 7
) (
    input  wire logic                core_clk,
    input  wire logic                sys_rst,
    input  wire logic                power_on_rst,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  ufc_pkg::ufc_rx_t         rx_char,
    input  wire logic [CNT_W-1:0]    rx_fifo_count,
    output ufc_pkg::ufc_rx_t         rx_fifo_wr,
    input  ufc_pkg::ufc_modem_t      modem_in_n,
    input  wire logic [7:0]          line_status_in,
    input  wire logic                tx_serial_in,
    input  wire logic                tx_ready_n_in,
    output logic                     tx_pin,
    output logic                     tx_allow,
    output logic                     rts_n,
    output logic                     dtr_n,
    output logic                     user_output_two_n,
    output logic                     transmit_ready_n,
    output logic                     irq,
    output logic                     irq_oe
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (CNT_W < 7 || CNT_W > 8) begin : g_bad_cnt_w
        $error("CNT_W must be 7 or 8");
    end
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]              efr_r, res1_r, res2_r, pau1_r, pau2_r, mcr_r;
    logic [7:0]              irq_stat_r, irq_mask_r, irq_id_r, trig_r, upper_r, lower_r;
    logic [7:0]              div_lo_r, div_hi_r, spr_r, enhanced_mode_select_r, lsr_r;
    logic [3:0]              delta_r;
    logic                    ack_r, trig_prev_r, paused_r;
    ufc_pkg::ufc_modem_t     modem_meta_r, modem_sync_r, modem_prev_r;
    ufc_pkg::ufc_rts_state_t rts_state_r, rts_state_nxt;
    ufc_pkg::ufc_rxfc_t      rxfc_mode;
    logic                    acc, wr_fire, rd_fire, is_pause, is_resume, is_special;
    logic [7:0]              wb_byte, cnt8, events, w1c, irq_stat_nxt, pend;
    logic [3:0]              modem_change;
    logic                    msr_rd, cts_stop, mcr_rts_n, cts_pin_n;
    assign cnt8      = 8'(rx_fifo_count);
    assign wb_byte   = wb_dat_i[7:0];
    assign mcr_rts_n = ~mcr_r[`UFC_MCR_RTS];
    assign cts_pin_n = modem_in_n.cts_n;
    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    // ack one cycle after the request; the write and any read side
    // effect act at the ack edge, the one the master samples
    assign acc      = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    assign rd_fire  = wb_cyc_i & wb_stb_i & ~wb_we_i & ack_r;
    assign wb_ack_o = ack_r;
    assign msr_rd   = rd_fire & (wb_adr_i == `UFC_OFS_MSR);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ack_r    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_r <= acc;
            if (acc) begin
                case (wb_adr_i)
                    `UFC_OFS_EFR:      wb_dat_o <= {24'h00_0000, efr_r};
                    `UFC_OFS_RES1:     wb_dat_o <= {24'h00_0000, res1_r};
                    `UFC_OFS_RES2:     wb_dat_o <= {24'h00_0000, res2_r};
                    `UFC_OFS_PAU1:     wb_dat_o <= {24'h00_0000, pau1_r};
                    `UFC_OFS_PAU2:     wb_dat_o <= {24'h00_0000, pau2_r};
                    `UFC_OFS_MCR:      wb_dat_o <= {24'h00_0000, mcr_r};
                    `UFC_OFS_MSR:      wb_dat_o <= {24'h00_0000, ~modem_sync_r, delta_r};
                    `UFC_OFS_IRQ_STAT: wb_dat_o <= {24'h00_0000, irq_stat_r};
                    `UFC_OFS_IRQ_MASK: wb_dat_o <= {24'h00_0000, irq_mask_r};
                    `UFC_OFS_LEVELS:   wb_dat_o <= {8'h00, lower_r, upper_r, trig_r};
                    `UFC_OFS_DIVISOR:  wb_dat_o <= {16'h0000, div_hi_r, div_lo_r};
                    `UFC_OFS_SPR:      wb_dat_o <= {24'h00_0000, spr_r};
                    `UFC_OFS_ENHANCED_MODE_SELECT:     wb_dat_o <= {24'h00_0000, enhanced_mode_select_r};
                    `UFC_OFS_LSR:      wb_dat_o <= {24'h00_0000, lsr_r};
                    `UFC_OFS_IRQ_ID:   wb_dat_o <= {24'h00_0000, irq_id_r};
                    default:           wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            efr_r      <= `UFC_RST_ZERO;
            res1_r     <= `UFC_RST_ZERO;
            res2_r     <= `UFC_RST_ZERO;
            pau1_r     <= `UFC_RST_ZERO;
            pau2_r     <= `UFC_RST_ZERO;
            mcr_r      <= `UFC_RST_ZERO;
            irq_mask_r <= `UFC_RST_ZERO;
            spr_r      <= `UFC_RST_SPR;
            enhanced_mode_select_r     <= `UFC_RST_ENHANCED_MODE_SELECT;
            trig_r     <= `UFC_RST_TRIG;
            upper_r    <= `UFC_RST_UPPER;
            lower_r    <= `UFC_RST_LOWER;
        end else if (wr_fire) begin
            case (wb_adr_i)
                `UFC_OFS_EFR:      if (wb_sel_i[0]) efr_r <= wb_byte;
                `UFC_OFS_RES1:     if (wb_sel_i[0]) res1_r <= wb_byte;
                `UFC_OFS_RES2:     if (wb_sel_i[0]) res2_r <= wb_byte;
                `UFC_OFS_PAU1:     if (wb_sel_i[0]) pau1_r <= wb_byte;
                `UFC_OFS_PAU2:     if (wb_sel_i[0]) pau2_r <= wb_byte;
                `UFC_OFS_MCR:      if (wb_sel_i[0]) mcr_r <= wb_byte;
                `UFC_OFS_IRQ_MASK: if (wb_sel_i[0]) irq_mask_r <= wb_byte;
                `UFC_OFS_SPR:      if (wb_sel_i[0]) spr_r <= wb_byte;
                `UFC_OFS_ENHANCED_MODE_SELECT:     if (wb_sel_i[0]) enhanced_mode_select_r <= wb_byte;
                `UFC_OFS_LEVELS: begin
                    if (wb_sel_i[0]) trig_r <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) upper_r <= wb_dat_i[15:8];
                    if (wb_sel_i[2]) lower_r <= wb_dat_i[23:16];
                end
                default: ;
            endcase
        end
    end
    // divisor survives the reset pin; only power-up sets it
    always_ff @(posedge core_clk) begin
        if (power_on_rst) begin
            div_hi_r <= `UFC_RST_DIV_HI;
            div_lo_r <= `UFC_RST_DIV_LO;
        end else if (wr_fire && wb_adr_i == `UFC_OFS_DIVISOR) begin
            if (wb_sel_i[0]) div_lo_r <= wb_dat_i[7:0];
            if (wb_sel_i[1]) div_hi_r <= wb_dat_i[15:8];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lsr_r <= `UFC_RST_LSR;
        end else begin
            lsr_r <= line_status_in;
        end
    end

    // ------------------------------------------------------------
    // modem inputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        modem_meta_r <= modem_in_n;
        modem_sync_r <= modem_meta_r;
    end
    assign modem_change = modem_sync_r ^ modem_prev_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            modem_prev_r <= 4'hf;
            delta_r      <= 4'h0;
        end else begin
            modem_prev_r <= modem_sync_r;
            // clear only the bits the read showed; a new change wins
            delta_r      <= (delta_r & ~(wb_dat_o[3:0] & {4{msr_rd}})) | modem_change;
        end
    end

    // ------------------------------------------------------------
    // receive compare
    // ------------------------------------------------------------
    assign rxfc_mode = ufc_pkg::ufc_rxfc_t'(efr_r[1:0]);
    always_comb begin
        is_pause  = 1'b0;
        is_resume = 1'b0;
        case (rxfc_mode)
            ufc_pkg::RXFC_ONE: begin
                is_pause  = rx_char.data == pau1_r;
                is_resume = rx_char.data == res1_r;
            end
            ufc_pkg::RXFC_TWO: begin
                is_pause  = rx_char.data == pau2_r;
                is_resume = rx_char.data == res2_r;
            end
            ufc_pkg::RXFC_BOTH: begin
                is_pause  = (rx_char.data == pau1_r) || (rx_char.data == pau2_r);
                is_resume = (rx_char.data == res1_r) || (rx_char.data == res2_r);
            end
            default: ;
        endcase
    end
    // whole-byte compare keeps bit 0 on the first data bit received
    assign is_special = efr_r[`UFC_EFR_SPECIAL] && (rx_char.data == pau2_r);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_fifo_wr <= '0;
        end else begin
            // flow characters are consumed; a special char that is not one is kept
            rx_fifo_wr.valid <= rx_char.valid & ~is_pause & ~is_resume;
            rx_fifo_wr.data  <= rx_char.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            paused_r <= 1'b0;
        end else if (rxfc_mode == ufc_pkg::RXFC_OFF) begin
            paused_r <= 1'b0;
        end else if (rx_char.valid && is_pause) begin
            paused_r <= 1'b1;
        end else if (rx_char.valid && is_resume) begin
            paused_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // auto request-to-send
    // ------------------------------------------------------------
    always_comb begin
        rts_state_nxt = rts_state_r;
        case (rts_state_r)
            ufc_pkg::RTS_OPEN: if (cnt8 >= upper_r) rts_state_nxt = ufc_pkg::RTS_HOLD;
            ufc_pkg::RTS_HOLD: if (cnt8 < lower_r) rts_state_nxt = ufc_pkg::RTS_OPEN;
            default:           rts_state_nxt = ufc_pkg::RTS_OPEN;
        endcase
        if (!efr_r[`UFC_EFR_AUTO_RTS]) rts_state_nxt = ufc_pkg::RTS_OPEN;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rts_state_r <= ufc_pkg::RTS_OPEN;
        end else begin
            rts_state_r <= rts_state_nxt;
        end
    end

    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rts_n             <= 1'b1;
            dtr_n             <= 1'b1;
            user_output_two_n <= 1'b1;
            irq_oe            <= 1'b0;
            tx_pin            <= 1'b1;
            transmit_ready_n  <= 1'b0;
        end else begin
            // auto hold can only lift an rts that software asserted
            rts_n             <= mcr_rts_n | (rts_state_nxt == ufc_pkg::RTS_HOLD);
            dtr_n             <= ~mcr_r[`UFC_MCR_DTR];
            user_output_two_n <= ~mcr_r[`UFC_MCR_OUT2];
            irq_oe            <= mcr_r[`UFC_MCR_OUT2];
            tx_pin            <= tx_serial_in;
            transmit_ready_n  <= tx_ready_n_in;
        end
    end
    // stop reaches tx_allow as soon as the two-stage synchroniser passes a high cts input
    assign cts_stop = efr_r[`UFC_EFR_AUTO_CTS] & modem_sync_r.cts_n;
    assign tx_allow = ~cts_stop & ~paused_r;
    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    always_comb begin
        events                  = 8'h00;
        events[`UFC_EV_TRIG]    = (cnt8 >= trig_r) & ~trig_prev_r;
        events[`UFC_EV_PAUSE]   = rx_char.valid & is_pause;
        events[`UFC_EV_RESUME]  = rx_char.valid & is_resume;
        events[`UFC_EV_MODEM]   = |modem_change;
        events[`UFC_EV_SPECIAL] = rx_char.valid & is_special;
    end
    assign w1c          = (wr_fire && wb_sel_i[0] && wb_adr_i == `UFC_OFS_IRQ_STAT) ? wb_byte : 8'h00;
    assign irq_stat_nxt = (irq_stat_r & ~w1c) | events;
    assign pend         = irq_stat_r & irq_mask_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_stat_r  <= `UFC_RST_ZERO;
            trig_prev_r <= 1'b0;
            irq         <= 1'b0;
            irq_id_r    <= `UFC_RST_IRQ_ID;
        end else begin
            irq_stat_r  <= irq_stat_nxt;
            trig_prev_r <= cnt8 >= trig_r;
            irq         <= |pend;
            irq_id_r    <= {2'b00, pend[4:0], ~(|pend)};
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_special_kept;
        @(posedge core_clk) disable iff (sys_rst)
        (rx_char.valid && efr_r[5] && efr_r[1:0] == 2'b10 && rx_char.data == pau2_r
         && rx_char.data != pau1_r && rx_char.data != res1_r)
        |=> (rx_fifo_wr.valid && irq_stat_r[4]);
    endproperty
    a_special_kept: assert property (p_special_kept) else $error("special char lost");
    property p_no_false_special;
        @(posedge core_clk) disable iff (sys_rst)
        (!irq_stat_r[4] && (!rx_char.valid || rx_char.data[0] != pau2_r[0]))
        |=> !irq_stat_r[4];
    endproperty
    a_no_false_special: assert property (p_no_false_special) else $error("bad special match");
    property p_pause_two_dropped;
        @(posedge core_clk) disable iff (sys_rst)
        (rx_char.valid && efr_r[5] && efr_r[1:0] == 2'b01 && rx_char.data == pau2_r)
        |=> (!rx_fifo_wr.valid && irq_stat_r[1] && irq_stat_r[4] ##1 tx_allow == 1'b0);
    endproperty
    a_pause_two_dropped: assert property (p_pause_two_dropped) else $error("pause two mishandled");
    property p_rts_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (efr_r[6] && cnt8 >= upper_r) |=> rts_n;
    endproperty
    a_rts_hold: assert property (p_rts_hold) else $error("rts not lifted at upper level");
    property p_rts_release;
        @(posedge core_clk) disable iff (sys_rst)
        (efr_r[6] && mcr_r[1] && rts_state_r == ufc_pkg::RTS_HOLD && cnt8 < lower_r)
        |=> !rts_n;
    endproperty
    a_rts_release: assert property (p_rts_release) else $error("rts not lowered");
    property p_rts_gpo;
        @(posedge core_clk) disable iff (sys_rst)
        (!efr_r[6] || !mcr_r[1]) |=> (rts_n == $past(mcr_rts_n));
    endproperty
    a_rts_gpo: assert property (p_rts_gpo) else $error("rts not following modem control");
    property p_cts_stop;
        @(posedge core_clk) disable iff (sys_rst)
        (efr_r[7] && $past(cts_pin_n, 2) && $past(cts_pin_n, 1) && cts_pin_n) |=> ##1 !tx_allow;
    endproperty
    a_cts_stop: assert property (p_cts_stop) else $error("tx not stopped by cts");
    property p_reset_state;
        @(posedge core_clk)
        sys_rst |=> (efr_r == 8'h00 && res1_r == 8'h00 && pau2_r == 8'h00 && rts_n && tx_pin
                     && !transmit_ready_n && !irq_oe && irq_id_r == 8'h01 && delta_r == 4'h0);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");
    property p_divisor_kept;
        @(posedge core_clk) disable iff (power_on_rst)
        sys_rst |=> (div_lo_r == $past(div_lo_r) && div_hi_r == $past(div_hi_r));
    endproperty
    a_divisor_kept: assert property (p_divisor_kept) else $error("divisor touched by reset");
endmodule : ufc_top

/* File: rtl/ufc_params.svh */
// offsets, field positions, reset values for the flow-control block
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define UFC_OFS_EFR      8'h00
`define UFC_OFS_RES1     8'h04
`define UFC_OFS_RES2     8'h08
`define UFC_OFS_PAU1     8'h0c
`define UFC_OFS_PAU2     8'h10
`define UFC_OFS_MCR      8'h14
`define UFC_OFS_MSR      8'h18
`define UFC_OFS_IRQ_STAT 8'h1c
`define UFC_OFS_IRQ_MASK 8'h20
`define UFC_OFS_LEVELS   8'h24
`define UFC_OFS_DIVISOR  8'h28
`define UFC_OFS_SPR      8'h2c
`define UFC_OFS_ENHANCED_MODE_SELECT     8'h30
`define UFC_OFS_LSR      8'h34
`define UFC_OFS_IRQ_ID   8'h38
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define UFC_EFR_SPECIAL  5
`define UFC_EFR_AUTO_RTS 6
`define UFC_EFR_AUTO_CTS 7
`define UFC_MCR_DTR      0
`define UFC_MCR_RTS      1
`define UFC_MCR_OUT2     3
`define UFC_EV_TRIG      0
`define UFC_EV_PAUSE     1
`define UFC_EV_RESUME    2
`define UFC_EV_MODEM     3
`define UFC_EV_SPECIAL   4
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define UFC_RST_ZERO     8'h00
`define UFC_RST_IRQ_ID   8'h01
`define UFC_RST_LSR      8'h60
`define UFC_RST_SPR      8'hff
`define UFC_RST_ENHANCED_MODE_SELECT     8'h80
`define UFC_RST_DIV_HI   8'h00
`define UFC_RST_DIV_LO   8'h01
`define UFC_RST_TRIG     8'h20
`define UFC_RST_UPPER    8'h28
`define UFC_RST_LOWER    8'h18
`endif

/* File: rtl/ufc_pkg.sv */
// types shared by the flow-control block
package ufc_pkg;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ufc_rx_t;
    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ufc_modem_t;
    typedef enum logic [1:0] {
        RTS_OPEN = 2'b01,
        RTS_HOLD = 2'b10
    } ufc_rts_state_t;
    typedef enum logic [1:0] {
        RXFC_OFF  = 2'b00,
        RXFC_TWO  = 2'b01,
        RXFC_ONE  = 2'b10,
        RXFC_BOTH = 2'b11
    } ufc_rxfc_t;
endpackage : ufc_pkg

/* File: bench/ufc_peer.sv */
// remote serial peer model: delivers received characters and drives the modem inputs
`timescale 1ns/1ps
module ufc_peer (
    input  wire logic           core_clk,
    output ufc_pkg::ufc_rx_t    rx_char,
    output ufc_pkg::ufc_modem_t modem_in_n
);
    // ----------------------------------------
    // line activity
    // ----------------------------------------
    initial begin
        rx_char = '0;
        modem_in_n = 4'hf;
    end
    // idle data shows the inverse of the last char, never a stale copy
    task automatic send(input logic [7:0] c);
        @(posedge core_clk) rx_char <= {1'b1, c};
        @(posedge core_clk) rx_char <= {1'b0, ~c};
    endtask : send
    task automatic cts(input logic e);
        @(posedge core_clk) modem_in_n.cts_n <= e;
    endtask : cts
endmodule : ufc_peer

/* File: bench/uart_auto_flow_special_char_bench.sv */
// self-checking bench for the flow-control and special character block
`timescale 1ns/1ps
module uart_auto_flow_special_char_bench;
    logic                core_clk, sys_rst, power_on_rst, wb_cyc_i, wb_stb_i, wb_we_i;
    logic                wb_ack_o, tx_serial_in, tx_ready_n_in, tx_pin, tx_allow, rts_n;
    logic                dtr_n, user_output_two_n, transmit_ready_n, irq, irq_oe;
    logic [7:0]          wb_adr_i, line_status_in;
    logic [3:0]          wb_sel_i;
    logic [31:0]         wb_dat_i, wb_dat_o;
    logic [6:0]          rx_fifo_count;
    ufc_pkg::ufc_rx_t    rx_char, rx_fifo_wr;
    ufc_pkg::ufc_modem_t modem_in_n;
    logic [31:0]         rq[$], fq[$];
    logic [7:0]          v[5];
    int                  err_total, total_checks;

    ufc_top #(.CNT_W(7)) u_dut (.core_clk, .sys_rst, .power_on_rst, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_char,
        .rx_fifo_count, .rx_fifo_wr, .modem_in_n, .line_status_in, .tx_serial_in,
        .tx_ready_n_in, .tx_pin, .tx_allow, .rts_n, .dtr_n, .user_output_two_n,
        .transmit_ready_n, .irq, .irq_oe);
    ufc_peer u_peer (.core_clk, .rx_char, .modem_in_n);

    // ----------------------------------------
    // checking
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pin(input int n, ref logic s, input logic e);
        repeat (n) @(negedge core_clk);
        chk({31'h0, s}, {31'h0, e});
    endtask : pin
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // an empty queue yields x, so a surplus result always counts as a mismatch
    always @(posedge core_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            chk(wb_dat_o, rq.size() != 0 ? rq.pop_front() : 32'hx);
        if (rx_fifo_wr.valid === 1'b1)
            chk({24'h0, rx_fifo_wr.data}, fq.size() != 0 ? fq.pop_front() : 32'hx);
    end
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #100us;
        err_total++;
        give_verdict();
    end
    initial begin
        void'($urandom(61311));
        {sys_rst, power_on_rst, wb_cyc_i, wb_stb_i, wb_we_i, tx_ready_n_in} = 6'h31;
        {wb_adr_i, wb_dat_i, rx_fifo_count, tx_serial_in} = '0;
        wb_sel_i = 4'hf;
        line_status_in = 8'($urandom);
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk({rts_n, dtr_n, user_output_two_n, tx_pin, transmit_ready_n, irq, irq_oe}, 7'h78);
        @(posedge core_clk) {sys_rst, power_on_rst} <= 2'b00;
        for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
        rd(8'h18, 32'h0);
        rd(8'h2c, 32'hff);
        rd(8'h30, 32'h80);
        rd(8'h38, 32'h01);
        rd(8'h28, 32'h0001);
        rd(8'h3c, 32'h0);
        rd(8'h24, 32'h0018_2820);
        rd(8'h34, {24'h0, line_status_in});
        bus(1'b1, 8'h28, 32'h0000_a5c3);
        @(posedge core_clk) sys_rst <= 1'b1;
        @(posedge core_clk) sys_rst <= 1'b0;
        rd(8'h28, 32'h0000_a5c3);
        // distinct top bits keep the four flow characters apart
        for (int i = 1; i < 5; i++) begin
            v[i] = {2'(i), 6'($urandom)};
            bus(1'b1, 8'(4 * i), {24'($urandom), v[i]});
            rd(8'(4 * i), {24'h0, v[i]});
        end
        bus(1'b1, 8'h14, 32'h2);
        pin(3, rts_n, 1'b0);
        bus(1'b1, 8'h00, 32'h40);
        @(posedge core_clk) rx_fifo_count <= 7'h27;
        pin(3, rts_n, 1'b0);
        @(posedge core_clk) rx_fifo_count <= 7'h28;
        pin(3, rts_n, 1'b1);
        rd(8'h1c, 32'h01);
        @(posedge core_clk) rx_fifo_count <= 7'h18;
        pin(3, rts_n, 1'b1);
        @(posedge core_clk) rx_fifo_count <= 7'h17;
        pin(3, rts_n, 1'b0);
        bus(1'b1, 8'h14, 32'h0);
        pin(3, rts_n, 1'b1);
        bus(1'b1, 8'h00, 32'h80);
        u_peer.cts(1'b1);
        pin(6, tx_allow, 1'b0);
        u_peer.cts(1'b0);
        pin(6, tx_allow, 1'b1);
        rd(8'h18, 32'h11);
        rd(8'h18, 32'h10);
        bus(1'b1, 8'h1c, 32'hff);
        bus(1'b1, 8'h00, 32'h20);
        fq.push_back({24'h0, v[4]});
        u_peer.send(v[4]);
        fq.push_back({24'h0, v[3]});
        u_peer.send(v[3]);
        rd(8'h1c, 32'h10);
        bus(1'b1, 8'h1c, 32'hff);
        bus(1'b1, 8'h00, 32'h22);
        fq.push_back({24'h0, v[4]});
        u_peer.send(v[4]);
        u_peer.send(v[3]);
        rd(8'h1c, 32'h12);
        bus(1'b1, 8'h1c, 32'hff);
        bus(1'b1, 8'h00, 32'h21);
        u_peer.send(v[4]);
        rd(8'h1c, 32'h12);
        pin(2, irq, 1'b0);
        bus(1'b1, 8'h20, 32'h10);
        bus(1'b1, 8'h14, 32'h08);
        pin(2, irq, 1'b1);
        chk({31'h0, irq_oe}, 32'h1);
        bus(1'b1, 8'h1c, 32'h12);
        pin(2, irq, 1'b0);
        u_peer.send(v[2]);
        pin(2, tx_allow, 1'b1);
        rd(8'h1c, 32'h04);
        bus(1'b1, 8'h00, 32'h03);
        u_peer.send(v[3]);
        pin(2, tx_allow, 1'b0);
        chk(32'(fq.size() + rq.size()), 32'h0);
        give_verdict();
    end
endmodule : uart_auto_flow_special_char_bench
